// ===== hw/lldp_pin_if.sv
// Contract
// - Address inputs are captured on each rising command clock edge.
// - Mode register set loads configuration from the address inputs.
// - Each command acts on the bank named by the bank select inputs; only reads and writes use it here.
// - Write enable, refresh and chip select, sampled at clock rise, define command.
// - Chip select high ignores new commands; running operations still finish.
// - Write data is sampled on both edges of the write data clock.
// - Read data is driven on both edges of the read data clock.
// - x36: lanes 0-17 use write clock 0, 18-35 clock 1; else clock 0.
// - Beats with write mask high are not written; mask uses write clock 1 in x36.
// - Read data clocks run free and are edge-aligned with read data.
// - Read clock 0 covers lanes 0-17/0-8/all by width; clock 1 the rest.
// - Read data valid marks valid beats, edge-aligned with read data clock.
// - Mode register bit 9 enables on-die termination of data inputs.
`timescale 1ns/1ps
`include "lldp_cfg.svh"

module lldp_pin_if import lldp_pkg::*; #(
	parameter int DEV_WIDTH = `LLDP_DEV_WIDTH,
	parameter int IDX_W     = `LLDP_IDX_W,
	parameter int READ_LAT  = `LLDP_READ_LAT
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_cmd_clock,
	input  wire logic                    i_cmd_clock_n,
	input  wire logic                    i_chip_select_n,
	input  wire logic                    i_write_enable_n,
	input  wire logic                    i_refresh_n,
	input  wire logic [`LLDP_BANK_W-1:0] i_bank_select,
	input  wire logic [`LLDP_ADDR_W-1:0] i_address_in,
	input  wire logic [1:0]              i_write_data_clock,
	input  wire logic [1:0]              i_write_data_clock_n,
	input  wire logic                    i_write_mask,
	input  wire logic [`LLDP_DQ_W-1:0]   i_data_bus,
	output logic      [`LLDP_DQ_W-1:0]   o_data_bus,
	output logic      [`LLDP_DQ_W-1:0]   o_data_bus_oe,
	output logic      [1:0]              o_read_data_clock,
	output logic      [1:0]              o_read_data_clock_n,
	output logic                         o_read_data_valid,
	output logic                         o_odt_enable,
	output logic      [`LLDP_ADDR_W-1:0] o_mode_reg,
	output logic                         o_refresh_pulse
);

	localparam int DQ_W   = `LLDP_DQ_W;
	localparam int HALF_W = `LLDP_HALF_W;
	localparam int MEM_AW = `LLDP_BANK_W + IDX_W;
	localparam logic [`LLDP_DIV_W-1:0] DIV_LAST = `LLDP_DIV_W'(`LLDP_RDCLK_HALF_CYC - 1);
	localparam logic [`LLDP_LAT_W-1:0] LAT_INIT = `LLDP_LAT_W'(READ_LAT);
	localparam logic [DQ_W-1:0] LANES = (DEV_WIDTH == 36) ? `LLDP_LANES_X36 :
		(DEV_WIDTH == 18) ? `LLDP_LANES_X18 : `LLDP_LANES_X9;

	// Clock edge events: bit 0 command, bit 1 write clock 0, bit 2 write clock 1
	logic [2:0]            clk_rise;
	logic [2:0]            clk_fall;
	lldp_cmd_t             cmd_pin;
	lldp_cmd_t             cmd_s1_reg;
	lldp_cmd_t             cmd_s2_reg;
	lldp_cmd_t             cmd_s3_reg;
	logic [DQ_W-1:0]       dq_s1_reg;
	logic [DQ_W-1:0]       dq_s2_reg;
	logic [DQ_W-1:0]       dq_s3_reg;
	logic [2:0]            dm_sync_reg;
	lldp_cmd_kind_t        cmd_kind;
	logic                  wr_pend_reg;
	logic [MEM_AW-1:0]     wr_addr_reg;
	logic [1:0]            half_done;
	logic [2*DQ_W-1:0]     wr_data;
	logic [1:0]            wr_keep;
	logic                  wr_commit;
	logic [MEM_AW-1:0]     rd_addr;
	logic [2*DQ_W-1:0]     rd_data;
	lldp_rd_state_t        rd_state_reg;
	logic [`LLDP_LAT_W-1:0] lat_cnt_reg;
	logic [`LLDP_DIV_W-1:0] div_cnt_reg;
	logic                  rclk_reg;
	logic                  rclk_n_reg;
	logic                  rclk_toggle;
	logic [`LLDP_ADDR_W-1:0] mode_reg;
	logic                  refresh_reg;
	logic [DQ_W-1:0]       dout_reg;
	logic [DQ_W-1:0]       oe_reg;
	logic                  valid_reg;

	lldp_diff_sync #(
		.W(3)
	) u_clk_sync (
		.i_clk  (i_core_clk),
		.i_rst  (i_rst),
		.i_p    ({i_write_data_clock[1], i_write_data_clock[0], i_cmd_clock}),
		.i_n    ({i_write_data_clock_n[1], i_write_data_clock_n[0], i_cmd_clock_n}),
		.o_rise (clk_rise),
		.o_fall (clk_fall)
	);

	// Third stage lines the pins up with the edge events
	assign cmd_pin = '{cs_n: i_chip_select_n, we_n: i_write_enable_n, ref_n: i_refresh_n,
		bank: i_bank_select, addr: i_address_in};

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cmd_s1_reg  <= '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, default: '0};
			cmd_s2_reg  <= '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, default: '0};
			cmd_s3_reg  <= '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, default: '0};
			dq_s1_reg   <= '0;
			dq_s2_reg   <= '0;
			dq_s3_reg   <= '0;
			dm_sync_reg <= 3'h0;
		end else begin
			cmd_s1_reg  <= cmd_pin;
			cmd_s2_reg  <= cmd_s1_reg;
			cmd_s3_reg  <= cmd_s2_reg;
			dq_s1_reg   <= i_data_bus;
			dq_s2_reg   <= dq_s1_reg;
			dq_s3_reg   <= dq_s2_reg;
			dm_sync_reg <= {dm_sync_reg[1:0], i_write_mask};
		end
	end

	// Command decode at the command clock rise
	always_comb begin
		cmd_kind = CMD_NONE;
		if (clk_rise[0] && !cmd_s3_reg.cs_n) begin
			unique case ({cmd_s3_reg.we_n, cmd_s3_reg.ref_n})
				2'b00: cmd_kind = CMD_MRS;
				2'b01: cmd_kind = CMD_WRITE;
				2'b10: cmd_kind = CMD_REFRESH;
				2'b11: cmd_kind = CMD_READ;
			endcase
		end
	end

	assign rd_addr = {cmd_s3_reg.bank, cmd_s3_reg.addr[IDX_W-1:0]};

	// Mode register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_reg <= `LLDP_MRS_RESET;
		end else if (cmd_kind == CMD_MRS) begin
			mode_reg <= cmd_s3_reg.addr;
		end
	end

	assign o_mode_reg   = mode_reg;
	assign o_odt_enable = mode_reg[`LLDP_MRS_ODT_BIT];

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			refresh_reg <= 1'b0;
		end else begin
			refresh_reg <= (cmd_kind == CMD_REFRESH);
		end
	end

	assign o_refresh_pulse = refresh_reg;

	// Write command tracking; a newer write replaces an unfinished one
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else if (cmd_kind == CMD_WRITE) begin
			wr_pend_reg <= 1'b1;
			wr_addr_reg <= rd_addr;
		end else if (wr_commit) begin
			wr_pend_reg <= 1'b0;
		end
	end

	// Per half capture of the two write beats
	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : gen_half
			localparam int SRC = (DEV_WIDTH == 36 && h == 1) ? 2 : 1;
			logic              got0_reg;
			logic              got1_reg;
			logic [HALF_W-1:0] beat0_reg;
			logic [HALF_W-1:0] beat1_reg;

			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					got0_reg  <= 1'b0;
					got1_reg  <= 1'b0;
					beat0_reg <= '0;
					beat1_reg <= '0;
				end else if (wr_commit || cmd_kind == CMD_WRITE) begin
					got0_reg <= 1'b0;
					got1_reg <= 1'b0;
				end else if (wr_pend_reg && !got0_reg && clk_rise[SRC]) begin
					got0_reg  <= 1'b1;
					beat0_reg <= dq_s3_reg[h*HALF_W +: HALF_W];
				end else if (got0_reg && !got1_reg && clk_fall[SRC]) begin
					got1_reg  <= 1'b1;
					beat1_reg <= dq_s3_reg[h*HALF_W +: HALF_W];
				end
			end

			assign half_done[h] = got1_reg;
			assign wr_data[h*HALF_W +: HALF_W]        = beat0_reg & LANES[h*HALF_W +: HALF_W];
			assign wr_data[DQ_W + h*HALF_W +: HALF_W] = beat1_reg & LANES[h*HALF_W +: HALF_W];

			// Mask follows the upper half clock, which is write clock 1 only in x36
			if (h == 1) begin : gen_mask
				logic mask0_reg;
				logic mask1_reg;

				always_ff @(posedge i_core_clk or posedge i_rst) begin
					if (i_rst) begin
						mask0_reg <= 1'b0;
						mask1_reg <= 1'b0;
					end else if (wr_pend_reg && !got0_reg && clk_rise[SRC]) begin
						mask0_reg <= dm_sync_reg[2];
					end else if (got0_reg && !got1_reg && clk_fall[SRC]) begin
						mask1_reg <= dm_sync_reg[2];
					end
				end

				assign wr_keep = {~mask1_reg, ~mask0_reg};
			end
		end
	endgenerate

	assign wr_commit = wr_pend_reg && (&half_done);

	lldp_bank_mem #(
		.W (DQ_W),
		.AW(MEM_AW)
	) u_mem (
		.i_clk    (i_core_clk),
		.i_we     (wr_commit),
		.i_beat_en(wr_keep),
		.i_waddr  (wr_addr_reg),
		.i_wdata  (wr_data),
		.i_re     (cmd_kind == CMD_READ && rd_state_reg == RD_IDLE),
		.i_raddr  (rd_addr),
		.o_rdata  (rd_data)
	);

	// Free running read data clock divider
	assign rclk_toggle = (div_cnt_reg == DIV_LAST);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			div_cnt_reg <= '0;
			rclk_reg    <= 1'b0;
			rclk_n_reg  <= 1'b1;
		end else if (rclk_toggle) begin
			div_cnt_reg <= '0;
			rclk_reg    <= ~rclk_reg;
			rclk_n_reg  <= rclk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + `LLDP_DIV_W'(1);
		end
	end

	// Both pairs share one source, so every lane group stays aligned
	assign o_read_data_clock   = {2{rclk_reg}};
	assign o_read_data_clock_n = {2{rclk_n_reg}};

	// Read sequencing; reads arriving while busy are dropped
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_state_reg <= RD_IDLE;
			lat_cnt_reg  <= '0;
		end else begin
			unique case (rd_state_reg)
				RD_IDLE: begin
					if (cmd_kind == CMD_READ) begin
						rd_state_reg <= RD_WAIT;
						lat_cnt_reg  <= LAT_INIT;
					end
				end
				RD_WAIT: begin
					if (lat_cnt_reg == '0) begin
						if (rclk_toggle && !rclk_reg) begin
							rd_state_reg <= RD_BEAT0;
						end
					end else if (clk_rise[0]) begin
						lat_cnt_reg <= lat_cnt_reg - `LLDP_LAT_W'(1);
					end
				end
				RD_BEAT0: begin
					if (rclk_toggle) begin
						rd_state_reg <= RD_BEAT1;
					end
				end
				RD_BEAT1: begin
					if (rclk_toggle) begin
						rd_state_reg <= RD_IDLE;
					end
				end
			endcase
		end
	end

	// Output beats change in the same cycle as the read clock edge
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dout_reg  <= '0;
			oe_reg    <= '0;
			valid_reg <= 1'b0;
		end else if (rclk_toggle) begin
			if (rd_state_reg == RD_WAIT && lat_cnt_reg == '0 && !rclk_reg) begin
				dout_reg  <= rd_data[DQ_W-1:0] & LANES;
				oe_reg    <= LANES;
				valid_reg <= 1'b1;
			end else if (rd_state_reg == RD_BEAT0) begin
				dout_reg <= rd_data[2*DQ_W-1:DQ_W] & LANES;
			end else if (rd_state_reg == RD_BEAT1) begin
				dout_reg  <= '0;
				oe_reg    <= '0;
				valid_reg <= 1'b0;
			end
		end
	end

	assign o_data_bus        = dout_reg;
	assign o_data_bus_oe     = oe_reg;
	assign o_read_data_valid = valid_reg;

endmodule

// ===== common/lldp_cfg.svh
`ifndef LLDP_CFG_SVH
`define LLDP_CFG_SVH

// Pin widths
`define LLDP_DQ_W            36
`define LLDP_HALF_W          18
`define LLDP_ADDR_W          22
`define LLDP_BANK_W          3
`define LLDP_DEV_WIDTH       36

// Lane enables per width
`define LLDP_LANES_X36       36'hF_FFFF_FFFF
`define LLDP_LANES_X18       36'h0_0003_FFFF
`define LLDP_LANES_X9        36'h0_0000_01FF

// Mode register
`define LLDP_MRS_ODT_BIT     9
`define LLDP_MRS_RESET       22'h00_0000

// Storage depth and read latency
`define LLDP_IDX_W           6
`define LLDP_READ_LAT        4
`define LLDP_LAT_W           4

// Read data clock period and its count of core cycles per half period
`define LLDP_CORE_PERIOD_PS  4000
`define LLDP_RDCLK_PERIOD_PS 80000
`define LLDP_RDCLK_HALF_CYC  ((`LLDP_RDCLK_PERIOD_PS / 2) / `LLDP_CORE_PERIOD_PS)
`define LLDP_DIV_W           8

`endif

// ===== common/lldp_pkg.sv
`include "lldp_cfg.svh"

package lldp_pkg;

	typedef struct packed {
		logic                        cs_n;
		logic                        we_n;
		logic                        ref_n;
		logic [`LLDP_BANK_W-1:0]     bank;
		logic [`LLDP_ADDR_W-1:0]     addr;
	} lldp_cmd_t;

	typedef enum logic [4:0] {
		CMD_NONE    = 5'b00001,
		CMD_READ    = 5'b00010,
		CMD_WRITE   = 5'b00100,
		CMD_REFRESH = 5'b01000,
		CMD_MRS     = 5'b10000
	} lldp_cmd_kind_t;

	typedef enum logic [3:0] {
		RD_IDLE  = 4'b0001,
		RD_WAIT  = 4'b0010,
		RD_BEAT0 = 4'b0100,
		RD_BEAT1 = 4'b1000
	} lldp_rd_state_t;

endpackage

// ===== hw/lldp_diff_sync.sv
`timescale 1ns/1ps

module lldp_diff_sync #(
	parameter int W = 3
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_p,
	input  wire logic [W-1:0] i_n,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	logic [W-1:0] p_s1_reg;
	logic [W-1:0] n_s1_reg;
	logic [W-1:0] p_s2_reg;
	logic [W-1:0] n_s2_reg;
	logic [W-1:0] lvl_reg;
	logic [W-1:0] prev_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			p_s1_reg <= '0;
			n_s1_reg <= '1;
			p_s2_reg <= '0;
			n_s2_reg <= '1;
		end else begin
			p_s1_reg <= i_p;
			n_s1_reg <= i_n;
			p_s2_reg <= p_s1_reg;
			n_s2_reg <= n_s1_reg;
		end
	end

	// Level moves only when the pair is truly complementary
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : gen_bit
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					lvl_reg[g]  <= 1'b0;
					prev_reg[g] <= 1'b0;
				end else begin
					if (p_s2_reg[g] != n_s2_reg[g]) begin
						lvl_reg[g] <= p_s2_reg[g];
					end
					prev_reg[g] <= lvl_reg[g];
				end
			end
		end
	endgenerate

	assign o_rise = lvl_reg & ~prev_reg;
	assign o_fall = ~lvl_reg & prev_reg;

endmodule

// ===== hw/lldp_bank_mem.sv
`timescale 1ns/1ps

module lldp_bank_mem #(
	parameter int W  = 36,
	parameter int AW = 9
) (
	input  wire logic          i_clk,
	input  wire logic          i_we,
	input  wire logic [1:0]    i_beat_en,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [2*W-1:0] i_wdata,
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [2*W-1:0] o_rdata
);

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : gen_beat
			logic [W-1:0] mem [2**AW];

			always_ff @(posedge i_clk) begin
				if (i_we && i_beat_en[b]) begin
					mem[i_waddr] <= i_wdata[b*W +: W];
				end
			end

			always_ff @(posedge i_clk) begin
				if (i_re) begin
					o_rdata[b*W +: W] <= mem[i_raddr];
				end
			end
		end
	endgenerate

endmodule

// ===== bench/lldp_pin_if_asserts.sv
`timescale 1ns/1ps
`include "lldp_cfg.svh"
module lldp_pin_if_asserts #(
	parameter int DEV_WIDTH = `LLDP_DEV_WIDTH
) (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_chip_select_n,
	input wire logic        i_write_enable_n,
	input wire logic        i_refresh_n,
	input wire logic [21:0] i_address_in,
	input wire logic [35:0] o_data_bus,
	input wire logic [35:0] o_data_bus_oe,
	input wire logic [1:0]  o_read_data_clock,
	input wire logic [1:0]  o_read_data_clock_n,
	input wire logic        o_read_data_valid,
	input wire logic        o_odt_enable,
	input wire logic [21:0] o_mode_reg,
	input wire logic        o_refresh_pulse
);
	localparam logic [35:0] LANES = DEV_WIDTH == 36 ? `LLDP_LANES_X36 :
		DEV_WIDTH == 18 ? `LLDP_LANES_X18 : `LLDP_LANES_X9;
	wire logic  rclk = o_read_data_clock[0];
	logic       rclk_prev_reg;
	logic [3:0] rclk_run_reg;
	// Cycles since the last read clock change; reset counts as a change
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rclk_prev_reg <= 1'b0;
			rclk_run_reg  <= 4'hF;
		end else begin
			rclk_prev_reg <= rclk;
			if (rclk != rclk_prev_reg) begin
				rclk_run_reg <= 4'h0;
			end else begin
				rclk_run_reg <= rclk_run_reg + 4'h1;
			end
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	rdclk_comp_a: assert property (o_read_data_clock_n == ~o_read_data_clock)
		else $error("read clock pair not complementary");
	rdclk_pair_a: assert property (o_read_data_clock[1] == rclk)
		else $error("read clocks differ");
	rdclk_half_a: assert property ($changed(rclk) |-> rclk_run_reg == 4'h9)
		else $error("read clock half period wrong");
	rdclk_stuck_a: assert property (rclk_run_reg != 4'hA)
		else $error("read clock stopped");
	valid_start_a: assert property ($rose(o_read_data_valid) |-> $rose(rclk))
		else $error("valid not aligned to read clock");
	valid_len_a: assert property ($rose(o_read_data_valid) |-> ##10 (o_read_data_valid && $fell(rclk))
		##10 (!o_read_data_valid && $rose(rclk))) else $error("valid length wrong");
	oe_lanes_a: assert property (o_data_bus_oe == (o_read_data_valid ? LANES : 36'h0))
		else $error("data enable wrong");
	data_edge_a: assert property ($changed(o_data_bus) |-> $changed(rclk))
		else $error("data changed off read clock edge");
	odt_bit_a: assert property (o_odt_enable == o_mode_reg[`LLDP_MRS_ODT_BIT])
		else $error("termination enable wrong");
	mode_load_a: assert property ($changed(o_mode_reg) |-> !$past(i_chip_select_n, 4) &&
		!$past(i_write_enable_n, 4) && !$past(i_refresh_n, 4) && o_mode_reg == $past(i_address_in, 4))
		else $error("mode register load wrong");
	refresh_cmd_a: assert property (o_refresh_pulse |-> !$past(i_chip_select_n, 4) &&
		$past(i_write_enable_n, 4) && !$past(i_refresh_n, 4) ##1 !o_refresh_pulse)
		else $error("refresh pulse wrong");
endmodule

bind lldp_pin_if lldp_pin_if_asserts #(.DEV_WIDTH(DEV_WIDTH)) u_lldp_pin_if_asserts (
	.i_core_clk, .i_rst, .i_chip_select_n, .i_write_enable_n, .i_refresh_n, .i_address_in,
	.o_data_bus, .o_data_bus_oe, .o_read_data_clock, .o_read_data_clock_n, .o_read_data_valid,
	.o_odt_enable, .o_mode_reg, .o_refresh_pulse);

// ===== bench/lldp_ctrl_model.sv
`timescale 1ns/1ps
module lldp_ctrl_model import lldp_pkg::*; (
	output logic        o_cmd_clock,
	output logic        o_cmd_clock_n,
	output lldp_cmd_t   o_cmd,
	output logic [1:0]  o_write_data_clock,
	output logic [1:0]  o_write_data_clock_n,
	output logic        o_write_mask,
	output logic [35:0] o_data_bus
);
	assign o_cmd_clock_n = ~o_cmd_clock;
	assign o_write_data_clock_n = ~o_write_data_clock;
	initial begin
		o_cmd = '1;
		o_write_mask = 1'h0;
		o_data_bus = 36'h0;
		o_cmd_clock = 1'h0;
		#3.3;
		forever #40 o_cmd_clock = ~o_cmd_clock;
	end
	// Write clocks run free, clock 1 leads by 4 ns
	initial begin
		o_write_data_clock = 2'h0;
		#9.3 o_write_data_clock[1] = 1'h1;
		#4 o_write_data_clock[0] = 1'h1;
		forever begin
			#36 o_write_data_clock[1] = ~o_write_data_clock[1];
			#4 o_write_data_clock[0] = ~o_write_data_clock[0];
		end
	end
	// Pins change at the fall, held across the rise
	task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [21:0] a);
		@(negedge o_cmd_clock);
		o_cmd = {c, b, a};
		@(posedge o_cmd_clock);
	endtask
	task automatic idle();
		@(negedge o_cmd_clock);
		o_cmd.cs_n = 1'h1;
		o_cmd.addr = ~o_cmd.addr;
	endtask
	task automatic op(input logic [2:0] c, input logic [2:0] b, input logic [21:0] a);
		cmd(c, b, a);
		idle();
	endtask
	task automatic wr(input logic [2:0] b, input logic [21:0] a, input logic [71:0] d, input logic [1:0] m);
		cmd(3'h1, b, a);
		fork
			idle();
			begin
				@(negedge o_write_data_clock[0]);
				o_data_bus = d[35:0];
				o_write_mask = m[0];
				@(posedge o_write_data_clock[0]);
				#20 o_data_bus = d[71:36];
				o_write_mask = m[1];
				@(negedge o_write_data_clock[0]);
				#20 o_data_bus = ~d[71:36];
				o_write_mask = 1'h0;
			end
		join
	endtask
endmodule

// ===== bench/lldp_pin_if_test.sv
`timescale 1ns/1ps
`include "lldp_cfg.svh"
module lldp_pin_if_test;
	logic                i_core_clk;
	logic                i_rst;
	lldp_pkg::lldp_cmd_t cmd;
	logic                cclk, cclk_n, wmask, vq, kq, valid, odt, rfp;
	logic [1:0]          wclk, wclk_n, rclk, rclk_n;
	logic [35:0]         mdq, rdq, oe, dq;
	logic [21:0]         mreg, a;
	logic [21:0]         adr [8];
	logic [71:0]         d;
	logic [71:0]         mem [512];
	logic [71:0]         expq [$];
	int                  miscompares, cmp_count, nref, n;
	assign dq = (oe & rdq) | (~oe & mdq);
	initial begin
		i_core_clk = 1'h0;
		forever #2 i_core_clk = ~i_core_clk;
	end
	lldp_ctrl_model u_lldp_ctrl_model (.o_cmd_clock(cclk), .o_cmd_clock_n(cclk_n), .o_cmd(cmd),
		.o_write_data_clock(wclk), .o_write_data_clock_n(wclk_n), .o_write_mask(wmask), .o_data_bus(mdq));
	lldp_pin_if u_lldp_pin_if (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_clock(cclk), .i_cmd_clock_n(cclk_n),
		.i_chip_select_n(cmd.cs_n), .i_write_enable_n(cmd.we_n), .i_refresh_n(cmd.ref_n),
		.i_bank_select(cmd.bank), .i_address_in(cmd.addr), .i_write_data_clock(wclk),
		.i_write_data_clock_n(wclk_n), .i_write_mask(wmask), .i_data_bus(dq), .o_data_bus(rdq),
		.o_data_bus_oe(oe), .o_read_data_clock(rclk), .o_read_data_clock_n(rclk_n),
		.o_read_data_valid(valid), .o_odt_enable(odt), .o_mode_reg(mreg), .o_refresh_pulse(rfp));
	task automatic check(input string nm, input logic [71:0] exp, input logic [71:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic drain();
		for (int t = 0; t < 400 && expq.size() != 0; t++)
			@(posedge i_core_clk);
		if (expq.size() != 0) begin
			miscompares++;
			$display("FAIL read valid expected 1 seen 0");
			results();
		end
		repeat (20) @(posedge i_core_clk);
	endtask
	always @(posedge i_core_clk) begin
		if (rfp === 1'h1)
			nref++;
		if (valid === 1'h1 && vq !== 1'h1) begin
			if (expq.size() == 0) begin
				check("read valid", 72'h0, {71'h0, valid});
			end else begin
				check("read beat0", expq[0][35:0], rdq);
				check("read lanes", `LLDP_LANES_X36, oe);
			end
		end
		if (valid === 1'h1 && kq === 1'h1 && rclk[0] === 1'h0 && expq.size() != 0) begin
			check("read beat1", expq[0][71:36], rdq);
			void'(expq.pop_front());
		end
		vq = valid;
		kq = rclk[0];
	end
	initial begin
		i_rst = 1'h1;
		vq = 1'h0;
		kq = 1'h0;
		nref = 0;
		n = $urandom(76354);
		repeat (10) @(posedge i_core_clk);
		#1 i_rst = 1'h0;
		repeat (4) @(posedge i_core_clk);
		check("mode reset", 72'h0, mreg);
		for (int i = 0; i < 4; i++) begin
			a = 22'($urandom);
			a[9] = i[0];
			u_lldp_ctrl_model.op(3'h0, 3'h0, a);
			check("mode reg", a, mreg);
			check("odt", a[9], odt);
		end
		u_lldp_ctrl_model.op(3'h4, 3'h0, ~a);
		check("mode hold", a, mreg);
		n = nref;
		u_lldp_ctrl_model.op(3'h2, 3'h0, a);
		u_lldp_ctrl_model.op(3'h6, 3'h0, a);
		check("refresh count", n + 1, nref);
		for (int b = 0; b < 8; b++) begin
			adr[b] = 22'($urandom);
			d = {8'($urandom), $urandom, $urandom};
			u_lldp_ctrl_model.wr(3'(b), adr[b], d, 2'h0);
			mem[{3'(b), adr[b][5:0]}] = d;
		end
		for (int m = 1; m < 3; m++) begin
			d = {8'($urandom), $urandom, $urandom};
			u_lldp_ctrl_model.wr(3'(m), adr[m], d, 2'(m));
			if (m == 1)
				mem[{3'(m), adr[m][5:0]}][71:36] = d[71:36];
			else
				mem[{3'(m), adr[m][5:0]}][35:0] = d[35:0];
		end
		for (int b = 0; b < 8; b++) begin
			expq.push_back(mem[{3'(b), adr[b][5:0]}]);
			u_lldp_ctrl_model.op(3'h3, 3'(b), adr[b]);
			drain();
		end
		u_lldp_ctrl_model.op(3'h7, 3'h0, adr[0]);
		repeat (200) @(posedge i_core_clk);
		results();
	end
endmodule
